// [include/pdsl_defs.vh]
// offsets, field positions, reset values and timing counts for the
// device status and link capabilities register bank.
// assumes inclusion by bare name from the design files.
`ifndef PDSL_DEFS_VH
`define PDSL_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PDSL_ADDR_W        12
`define PDSL_OFF_DCTL      12'h048
`define PDSL_OFF_DSTS      12'h04A
`define PDSL_OFF_LCAP      12'h04C

// ----------------------------------------
// device control upper fields (all zero)
// ----------------------------------------
`define PDSL_DCTL_PHANTOM  9
`define PDSL_DCTL_AUXPM    10
`define PDSL_DCTL_NOSNOOP  11
`define PDSL_DCTL_MAX_READ_REQUEST_SIZE_LO  12
`define PDSL_DCTL_MAX_READ_REQUEST_SIZE_HI  14
`define PDSL_DCTL_RST      16'h0000

// ----------------------------------------
// device status fields
// ----------------------------------------
`define PDSL_DSTS_NFLAGS   4
`define PDSL_DSTS_AUX_POWER_DETECTED    4
`define PDSL_DSTS_TPEND    5
`define PDSL_DSTS_RST      4'h0

// ----------------------------------------
// link capabilities fields and defaults
// ----------------------------------------
`define PDSL_LCAP_SPD_LO   0
`define PDSL_LCAP_SPD_HI   3
`define PDSL_LCAP_WID_LO   4
`define PDSL_LCAP_WID_HI   9
`define PDSL_LCAP_ASPM_LO  10
`define PDSL_LCAP_ASPM_HI  11
`define PDSL_LCAP_L0S_LO   12
`define PDSL_LCAP_L0S_HI   14
`define PDSL_LCAP_L1_LO    15
`define PDSL_LCAP_L1_HI    17
`define PDSL_LCAP_CPM      18
`define PDSL_LCAP_SURPRISE_DOWN_REPORTING    19
`define PDSL_LCAP_DLLA     20
`define PDSL_LCAP_SPD_RST  4'h2
`define PDSL_LCAP_WID_RST  6'h04
`define PDSL_LCAP_ASPM_RST 2'h3
`define PDSL_LCAP_L0S_RST  3'h6
`define PDSL_LCAP_L1_RST   3'h2
`define PDSL_LCAP_CPM_RST  1'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define PDSL_CLK_PS        20000
`define PDSL_L1_EXIT_PS    2300000
`define PDSL_L1_EXIT_CYC   ((`PDSL_L1_EXIT_PS + `PDSL_CLK_PS - 1) / `PDSL_CLK_PS)

`endif

// [verilog/pdsl_sticky.v]
// bank of sticky event flags cleared by writing one.
// assumes event pulses and clear strobes are synchronous to clk_sys.
`timescale 1ns/1ps

module pdsl_sticky #(
	parameter N = 4
) (
	input  wire         clk_sys,
	input  wire         rst,
	input  wire [N-1:0] set_evt,
	input  wire [N-1:0] clr_one,
	output wire [N-1:0] flag
);

	// ----------------------------------------
	// one flip-flop per flag
	// ----------------------------------------
	reg  [N-1:0] flag_ff;     // held flags
	wire [N-1:0] nxt_flag;    // next flag values

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_flag
			// a set in the clearing cycle wins
			assign nxt_flag[i] = set_evt[i] |
				(flag_ff[i] & ~clr_one[i]);
		end
	endgenerate

	// update every flag on each edge
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_ff <= {N{1'b0}};
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;

endmodule

// [verilog/pdsl_regs.v]
// device status, upper device control and link capabilities registers
// of one switch port, reached through a plain config port.
// assumes one clock, async reset, config master holds strobes one cycle.
`timescale 1ns/1ps
`include "pdsl_defs.vh"

module pdsl_regs #(
	parameter L1_EXIT_CYC = `PDSL_L1_EXIT_CYC
) (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire [11:0] cfg_addr,
	input  wire [31:0] cfg_wdata,
	input  wire        cfg_wr,
	input  wire        cfg_rd,
	output wire [31:0] cfg_rdata,
	input  wire        port_downstream,
	input  wire        corr_err_evt,
	input  wire        nonfatal_err_evt,
	input  wire        fatal_err_evt,
	input  wire        unsup_req_evt,
	input  wire [3:0]  err_report_en,
	output wire [3:0]  err_msg_req,
	output wire [5:0]  link_width_eff,
	input  wire        l1_exit_start,
	output wire        l1_exit_busy,
	output wire        l1_exit_done
);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------

	// true when the address selects the given offset
	function hit;
		input [11:0] addr;
		input [11:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// true for a width code the port can run
	function width_ok;
		input [5:0] code;
		begin
			width_ok = (code == 6'h01) | (code == 6'h02) |
				(code == 6'h04) | (code == 6'h08);
		end
	endfunction

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	wire wr_dsts;             // write to device status
	wire wr_lcap;             // write to link capabilities
	wire rd_dctl;             // read of device control
	wire rd_dsts;             // read of device status
	wire rd_lcap;             // read of link capabilities

	assign wr_dsts = cfg_wr & hit(cfg_addr, `PDSL_OFF_DSTS);
	assign wr_lcap = cfg_wr & hit(cfg_addr, `PDSL_OFF_LCAP);
	assign rd_dctl = cfg_rd & hit(cfg_addr, `PDSL_OFF_DCTL);
	assign rd_dsts = cfg_rd & hit(cfg_addr, `PDSL_OFF_DSTS);
	assign rd_lcap = cfg_rd & hit(cfg_addr, `PDSL_OFF_LCAP);

	// ----------------------------------------
	// device control upper half
	// ----------------------------------------
	// nothing here is stored: writes to device control are dropped
	wire [15:0] dctl_view;    // value shown on read

	// phantom, aux pm, no snoop and request size are all zero
	assign dctl_view = `PDSL_DCTL_RST;

	// ----------------------------------------
	// device status flags
	// ----------------------------------------
	wire [3:0] err_evt;       // raw error events
	wire [3:0] err_clr;       // write-one clear strobes
	wire [3:0] err_flag;      // sticky flags

	// events feed the flags with no enable gating
	assign err_evt = {unsup_req_evt, fatal_err_evt,
		nonfatal_err_evt, corr_err_evt};

	// a zero written leaves the matching flag alone
	assign err_clr = wr_dsts ? cfg_wdata[3:0] : 4'h0;

	pdsl_sticky #(
		.N (`PDSL_DSTS_NFLAGS)
	) u_flags (
		.clk_sys (clk_sys),
		.rst     (rst),
		.set_evt (err_evt),
		.clr_one (err_clr),
		.flag    (err_flag)
	);

	wire [15:0] dsts_view;    // value shown on read

	// aux power and pending bits are hardwired low
	assign dsts_view = {10'h000, 1'b0, 1'b0, err_flag};

	// ----------------------------------------
	// reporting path, gated by the enables
	// ----------------------------------------
	reg  [3:0] err_msg_ff;    // one-cycle report requests
	wire [3:0] nxt_err_msg;   // next report requests

	// only enabled events turn into report requests
	assign nxt_err_msg = err_evt & err_report_en;

	// register the gated report pulses
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			err_msg_ff <= 4'h0;
		end else begin
			err_msg_ff <= nxt_err_msg;
		end
	end

	assign err_msg_req = err_msg_ff;

	// ----------------------------------------
	// link capabilities storage
	// ----------------------------------------
	reg  [5:0] width_ff;      // advertised max width
	reg  [1:0] aspm_ff;       // aspm support
	reg  [2:0] l0s_ff;        // l0s exit latency
	reg  [2:0] l1_ff;         // l1 exit latency
	reg        cpm_ff;        // clock power management
	reg        surprise_down_reporting_ff;      // surprise down reporting
	reg        dlla_ff;       // link active reporting
	reg        load_ff;       // port defaults still to load
	reg        down_ff;       // port faces downstream
	reg  [5:0] nxt_width;
	reg  [1:0] nxt_aspm;
	reg  [2:0] nxt_l0s;
	reg  [2:0] nxt_l1;
	reg        nxt_cpm;
	reg        nxt_surprise_down_reporting;
	reg        nxt_dlla;
	reg        nxt_down;

	// next values: port defaults once after reset, then writes
	always @* begin
		nxt_width = width_ff;
		nxt_aspm  = aspm_ff;
		nxt_l0s   = l0s_ff;
		nxt_l1    = l1_ff;
		nxt_cpm   = cpm_ff;
		nxt_surprise_down_reporting = surprise_down_reporting_ff;
		nxt_dlla  = dlla_ff;
		nxt_down  = down_ff;
		if (load_ff) begin
			// direction strap caught just after release
			// and kept to gate later writes of the port bits
			nxt_down  = port_downstream;
			nxt_surprise_down_reporting = port_downstream;
			nxt_dlla  = port_downstream;
		end else if (wr_lcap) begin
			// width is kept exactly as written
			nxt_width = cfg_wdata[`PDSL_LCAP_WID_HI:
				`PDSL_LCAP_WID_LO];
			nxt_aspm  = cfg_wdata[`PDSL_LCAP_ASPM_HI:
				`PDSL_LCAP_ASPM_LO];
			nxt_l0s   = cfg_wdata[`PDSL_LCAP_L0S_HI:
				`PDSL_LCAP_L0S_LO];
			nxt_l1    = cfg_wdata[`PDSL_LCAP_L1_HI:
				`PDSL_LCAP_L1_LO];
			nxt_cpm   = cfg_wdata[`PDSL_LCAP_CPM];
			// an upstream port keeps both port bits at zero,
			// since neither capability applies there
			nxt_surprise_down_reporting = cfg_wdata[`PDSL_LCAP_SURPRISE_DOWN_REPORTING] &
				down_ff;
			// only the advertised bit changes
			nxt_dlla  = cfg_wdata[`PDSL_LCAP_DLLA] &
				down_ff;
		end
	end

	// capability flip-flops; reset loads fixed defaults
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			width_ff <= `PDSL_LCAP_WID_RST;
			aspm_ff  <= `PDSL_LCAP_ASPM_RST;
			l0s_ff   <= `PDSL_LCAP_L0S_RST;
			l1_ff    <= `PDSL_LCAP_L1_RST;
			cpm_ff   <= `PDSL_LCAP_CPM_RST;
			surprise_down_reporting_ff <= 1'b0;
			dlla_ff  <= 1'b0;
			down_ff  <= 1'b0;
			load_ff  <= 1'b1;
		end else begin
			width_ff <= nxt_width;
			aspm_ff  <= nxt_aspm;
			l0s_ff   <= nxt_l0s;
			l1_ff    <= nxt_l1;
			cpm_ff   <= nxt_cpm;
			surprise_down_reporting_ff <= nxt_surprise_down_reporting;
			dlla_ff  <= nxt_dlla;
			down_ff  <= nxt_down;
			load_ff  <= 1'b0;
		end
	end

	wire [31:0] lcap_view;    // value shown on read

	// speed is a constant; bits 31:21 lie elsewhere and read zero
	assign lcap_view = {11'h000, dlla_ff, surprise_down_reporting_ff, cpm_ff,
		l1_ff, l0s_ff, aspm_ff, width_ff,
		`PDSL_LCAP_SPD_RST};

	// ----------------------------------------
	// width the link actually trains to
	// ----------------------------------------
	reg  [5:0] width_eff_ff;  // width handed to the link
	wire [5:0] nxt_width_eff;

	// a bad code falls back to the initial width
	assign nxt_width_eff = width_ok(width_ff) ? width_ff :
		`PDSL_LCAP_WID_RST;

	// register the effective width
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			width_eff_ff <= `PDSL_LCAP_WID_RST;
		end else begin
			width_eff_ff <= nxt_width_eff;
		end
	end

	assign link_width_eff = width_eff_ff;

	// ----------------------------------------
	// l1 to l0 return timer
	// ----------------------------------------
	localparam ST_IDLE = 1'b0;   // link in l0 or l1
	localparam ST_EXIT = 1'b1;   // leaving l1

	reg        st_ff;         // timer state
	reg        nxt_st;
	reg [15:0] cnt_ff;        // cycles left in the exit
	reg [15:0] nxt_cnt;
	reg        done_ff;       // exit finished pulse
	reg        nxt_done;

	// the exit always lasts the same fixed time
	always @* begin
		nxt_st   = st_ff;
		nxt_cnt  = cnt_ff;
		nxt_done = 1'b0;
		case (st_ff)
			ST_IDLE: begin
				if (l1_exit_start) begin
					nxt_st  = ST_EXIT;
					nxt_cnt = L1_EXIT_CYC[15:0] - 16'h0001;
				end
			end
			ST_EXIT: begin
				if (cnt_ff == 16'h0000) begin
					nxt_st   = ST_IDLE;
					nxt_done = 1'b1;
				end else begin
					nxt_cnt = cnt_ff - 16'h0001;
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	// timer flip-flops
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff   <= ST_IDLE;
			cnt_ff  <= 16'h0000;
			done_ff <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	// busy covers the whole exit, done follows it
	assign l1_exit_busy = st_ff;
	assign l1_exit_done = done_ff;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	reg  [31:0] rdata_ff;     // read answer, one cycle late
	reg  [31:0] nxt_rdata;

	// select the addressed view; unmapped reads return zero
	always @* begin
		nxt_rdata = 32'h00000000;
		if (rd_dctl) begin
			nxt_rdata = {16'h0000, dctl_view};
		end else if (rd_dsts) begin
			nxt_rdata = {16'h0000, dsts_view};
		end else if (rd_lcap) begin
			nxt_rdata = lcap_view;
		end
	end

	// read data register
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// the answer stands for one cycle, then falls to zero
	assign cfg_rdata = rdata_ff;

endmodule

// [tb/pdsl_regs_monitor.sv]
// checker for the status and link capability bank.
// assumes it is bound to pdsl_regs; one clock, async reset.
`timescale 1ns/1ps
`include "pdsl_defs.vh"
module pdsl_regs_monitor #(
	parameter L1_EXIT_CYC = 115
) (
	input wire        clk_sys,
	input wire        rst,
	input wire [11:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	input wire        cfg_wr,
	input wire        cfg_rd,
	input wire [31:0] cfg_rdata,
	input wire        port_downstream,
	input wire        corr_err_evt,
	input wire        nonfatal_err_evt,
	input wire        fatal_err_evt,
	input wire        unsup_req_evt,
	input wire [3:0]  err_report_en,
	input wire [3:0]  err_msg_req,
	input wire [5:0]  link_width_eff,
	input wire        l1_exit_start,
	input wire        l1_exit_busy,
	input wire        l1_exit_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// helper decode
	// ----------------------------------------
	reg  [15:0] busy_ff; // busy cycles seen so far
	wire        rd_c = cfg_rd && cfg_addr == `PDSL_OFF_DCTL;
	wire        rd_d = cfg_rd && cfg_addr == `PDSL_OFF_DSTS;
	wire        rd_l = cfg_rd && cfg_addr == `PDSL_OFF_LCAP;
	wire        wr_l = cfg_wr && cfg_addr == `PDSL_OFF_LCAP;
	wire [5:0]  wc = cfg_wdata[9:4];
	wire        ok_w = wc == 6'h01 || wc == 6'h02 || wc == 6'h04
		|| wc == 6'h08;
	wire [3:0]  evt_v = {unsup_req_evt, fatal_err_evt, nonfatal_err_evt,
		corr_err_evt} & err_report_en;
	// counts the exit window, cleared once busy drops
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			busy_ff <= 16'h0000;
		else
			busy_ff <= l1_exit_busy ? busy_ff + 16'h0001 : 16'h0000;
	end
	sequence s_corr; corr_err_evt ##[1:2] rd_d; endsequence
	sequence s_fat; fatal_err_evt ##[1:2] rd_d; endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_DCTL_ZERO: assert property (
		$past(rd_c) |-> cfg_rdata == 32'h0) else $error("ctl not zero");
	AST_STS_RO: assert property (
		$past(rd_d) |-> cfg_rdata[31:4] == 28'h0) else $error("sts ro");
	AST_SPEED: assert property (
		$past(rd_l) |-> cfg_rdata[3:0] == 4'h2) else $error("speed");
	AST_CORR: assert property (
		s_corr |=> cfg_rdata[0]) else $error("corr flag lost");
	AST_FATAL: assert property (
		s_fat |=> cfg_rdata[2]) else $error("fatal flag lost");
	AST_MSG: assert property (
		err_msg_req == $past(evt_v)) else $error("msg request");
	AST_W_OK: assert property (
		wr_l && ok_w |-> ##2 link_width_eff == $past(wc, 2))
		else $error("width not used");
	AST_W_BAD: assert property (
		wr_l && !ok_w |-> ##2 link_width_eff == 6'h04)
		else $error("bad width not x4");
	AST_L1: assert property (
		l1_exit_done |-> busy_ff == L1_EXIT_CYC) else $error("l1 exit");
	AST_L1_GO: assert property (
		l1_exit_start && !l1_exit_busy |=> l1_exit_busy)
		else $error("exit not started");
	AST_UP_ZERO: assert property (
		$past(rd_l) && !port_downstream |-> cfg_rdata[20:19] == 2'b00)
		else $error("upstream port bits set");
endmodule

bind pdsl_regs pdsl_regs_monitor #(
	.L1_EXIT_CYC (L1_EXIT_CYC)
) u_mon (
	.clk_sys          (clk_sys),
	.rst              (rst),
	.cfg_addr         (cfg_addr),
	.cfg_wdata        (cfg_wdata),
	.cfg_wr           (cfg_wr),
	.cfg_rd           (cfg_rd),
	.cfg_rdata        (cfg_rdata),
	.port_downstream  (port_downstream),
	.corr_err_evt     (corr_err_evt),
	.nonfatal_err_evt (nonfatal_err_evt),
	.fatal_err_evt    (fatal_err_evt),
	.unsup_req_evt    (unsup_req_evt),
	.err_report_en    (err_report_en),
	.err_msg_req      (err_msg_req),
	.link_width_eff   (link_width_eff),
	.l1_exit_start    (l1_exit_start),
	.l1_exit_busy     (l1_exit_busy),
	.l1_exit_done     (l1_exit_done)
);

// [tb/pdsl_host.sv]
// config master standing in for host software.
// assumes read data stand only in the cycle after the strobe.
`timescale 1ns/1ps
module pdsl_host (
	input  wire        clk_sys,
	output reg  [11:0] cfg_addr,
	output reg  [31:0] cfg_wdata,
	output reg         cfg_wr,
	output reg         cfg_rd,
	input  wire [31:0] cfg_rdata
);
	initial begin
		cfg_addr = 12'h000;
		cfg_wdata = 32'h0;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
	end
	// one write cycle; idle lines show inverted values afterwards
	task wr_cyc(input [11:0] a, input [31:0] d);
		begin
			@(posedge clk_sys);
			cfg_wr <= 1'b1;
			cfg_addr <= a;
			cfg_wdata <= d;
			@(posedge clk_sys);
			cfg_wr <= 1'b0;
			cfg_addr <= ~a;
			cfg_wdata <= ~d;
		end
	endtask
	// one read cycle; data taken at the edge closing the answer cycle
	task rd_cyc(input [11:0] a, output [31:0] d);
		begin
			@(posedge clk_sys);
			cfg_rd <= 1'b1;
			cfg_addr <= a;
			@(posedge clk_sys);
			cfg_rd <= 1'b0;
			cfg_addr <= ~a;
			@(posedge clk_sys);
			d = cfg_rdata;
		end
	endtask
endmodule

// [tb/pdsl_regs_tb.sv]
// self-checking bench for the status and link capability bank.
// assumes pdsl_host as config master and the bound checker.
`timescale 1ns/1ps
`include "pdsl_defs.vh"
module pdsl_regs_tb;
	localparam L1C = 5; // short exit count for simulation
	reg         clk_sys, rst, ds, l1s;
	reg  [3:0]  evt, en;
	reg  [31:0] d;
	wire [11:0] a;
	wire [31:0] wd, rdat;
	wire        wr, rd, busy, done;
	wire [3:0]  msg;
	wire [5:0]  weff;
	integer     fail_count, samples_checked, cyc;

	pdsl_host u_host (.clk_sys(clk_sys), .cfg_addr(a), .cfg_wdata(wd),
		.cfg_wr(wr), .cfg_rd(rd), .cfg_rdata(rdat));
	pdsl_regs #(.L1_EXIT_CYC(L1C)) dut (.clk_sys(clk_sys), .rst(rst),
		.cfg_addr(a), .cfg_wdata(wd), .cfg_wr(wr), .cfg_rd(rd),
		.cfg_rdata(rdat), .port_downstream(ds), .corr_err_evt(evt[0]),
		.nonfatal_err_evt(evt[1]), .fatal_err_evt(evt[2]),
		.unsup_req_evt(evt[3]), .err_report_en(en), .err_msg_req(msg),
		.link_width_eff(weff), .l1_exit_start(l1s),
		.l1_exit_busy(busy), .l1_exit_done(done));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input [31:0] g, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("BAD %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d bad %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			$display("BAD %0t timeout", $time);
			end_sim;
		end
	end
	function [31:0] lcap_def(input v);
		lcap_def = {11'h000, v, v, 1'b0, 3'h2, 3'h6, 2'h3, 6'h04, 4'h2};
	endfunction
	task pulse(input [3:0] e);
		begin
			@(posedge clk_sys);
			evt <= e;
			@(posedge clk_sys);
			evt <= 4'h0;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset with a port direction, then every default
	task t_defaults(input v);
		begin
			@(posedge clk_sys);
			rst <= 1'b1;
			ds <= v;
			repeat (4) @(posedge clk_sys);
			rst <= 1'b0;
			@(posedge clk_sys);
			u_host.rd_cyc(`PDSL_OFF_DCTL, d);
			chk(d, 32'h0);
			u_host.rd_cyc(`PDSL_OFF_DSTS, d);
			chk(d, 32'h0);
			u_host.rd_cyc(`PDSL_OFF_LCAP, d);
			chk(d, lcap_def(v));
			chk({29'h0, d[14:12]}, {29'h0, `PDSL_LCAP_L0S_RST});
			chk({31'h0, d[18]}, {31'h0, `PDSL_LCAP_CPM_RST});
			// port bits take a write only on a downstream port
			u_host.wr_cyc(`PDSL_OFF_LCAP, 32'h00180000);
			u_host.rd_cyc(`PDSL_OFF_LCAP, d);
			chk(d, {11'h000, v, v, 19'h00002});
		end
	endtask
	// read-only bits ignore writes of ones
	task t_ro;
		begin
			u_host.wr_cyc(`PDSL_OFF_DCTL, 32'hFFFFFFFF);
			u_host.rd_cyc(`PDSL_OFF_DCTL, d);
			chk(d, 32'h0);
			chk({29'h0, d[14:12]}, 32'h0);
			u_host.wr_cyc(`PDSL_OFF_DSTS, 32'hFFFFFFF0);
			u_host.rd_cyc(`PDSL_OFF_DSTS, d);
			chk(d, 32'h0);
		end
	endtask
	// each flag sets, survives a zero write, clears on one
	task t_flags;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				en <= i[0] ? 4'hF : 4'h0;
				pulse(4'h1 << i);
				u_host.rd_cyc(`PDSL_OFF_DSTS, d);
				chk(d, 32'h1 << i);
				u_host.wr_cyc(`PDSL_OFF_DSTS, 32'h0);
				u_host.rd_cyc(`PDSL_OFF_DSTS, d);
				chk(d, 32'h1 << i);
				u_host.wr_cyc(`PDSL_OFF_DSTS, 32'h1 << i);
				u_host.rd_cyc(`PDSL_OFF_DSTS, d);
				chk(d, 32'h0);
			end
			// event in the clearing cycle keeps the flag
			fork
				u_host.wr_cyc(`PDSL_OFF_DSTS, 32'h8);
				pulse(4'h8);
			join
			u_host.rd_cyc(`PDSL_OFF_DSTS, d);
			chk(d, 32'h8);
			u_host.wr_cyc(`PDSL_OFF_DSTS, 32'h8);
		end
	endtask
	// width codes, then every overridable field
	task t_caps;
		integer i;
		reg [5:0] c;
		begin
			for (i = 0; i < 6; i = i + 1) begin
				c = (i == 4) ? 6'h03 : (i == 5) ? 6'h3F : 6'h01 << i;
				u_host.wr_cyc(`PDSL_OFF_LCAP, {22'h0, c, 4'h0});
				u_host.rd_cyc(`PDSL_OFF_LCAP, d);
				chk({26'h0, d[9:4]}, {26'h0, c});
				chk({26'h0, weff}, {26'h0, i < 4 ? c : 6'h04});
			end
			u_host.wr_cyc(`PDSL_OFF_LCAP, 32'hFFFFFFFF);
			u_host.rd_cyc(`PDSL_OFF_LCAP, d);
			chk(d, 32'h001FFFF2);
			u_host.wr_cyc(`PDSL_OFF_LCAP, 32'h0);
			u_host.wr_cyc(12'h050, 32'hFFFFFFFF);
			u_host.rd_cyc(12'h050, d);
			chk(d, 32'h0);
			u_host.rd_cyc(`PDSL_OFF_LCAP, d);
			chk(d, 32'h00000002);
		end
	endtask
	// exit lasts the set count; a start while busy is ignored
	task t_l1;
		integer n;
		begin
			@(posedge clk_sys);
			l1s <= 1'b1;
			@(posedge clk_sys);
			l1s <= 1'b0;
			n = 0;
			while (done !== 1'b1 && n < 40) begin
				@(posedge clk_sys);
				n = n + 1;
				l1s <= (n == 2);
			end
			chk(n, L1C + 1);
			@(posedge clk_sys);
			chk({31'h0, busy}, 32'h0);
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		ds = 1'b1;
		l1s = 1'b0;
		evt = 4'h0;
		en = 4'h0;
		fail_count = 0;
		samples_checked = 0;
		cyc = 0;
		t_defaults(1'b1);
		t_ro;
		t_flags;
		t_caps;
		t_l1;
		pulse(4'hF);
		t_defaults(1'b0);
		end_sim;
	end
endmodule
